// ==== rtl/swac_pkg.sv ====
package swac_pkg;
   localparam int SWAC_MAP_W = 24;
   localparam int SWAC_PICK_W = 4;
   localparam int SWAC_TAD_W = 8;
   localparam int SWAC_ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] SWAC_IDX_CLK_CTRL = 8'h29;
   localparam logic [7:0] SWAC_IDX_MAP_LOW = 8'h2c;
   localparam logic [7:0] SWAC_IDX_MAP_MID = 8'h2d;
   localparam logic [7:0] SWAC_IDX_MAP_HIGH = 8'h2e;
   localparam logic [7:0] SWAC_IDX_MAP_STAT = 8'h2f;
   localparam logic [7:0] SWAC_IDX_CAL_GO = 8'h30;
   localparam logic [7:0] SWAC_IDX_CAL_SETUP = 8'h31;
   localparam logic [7:0] SWAC_IDX_CAL_STAT = 8'h32;
   localparam logic [7:0] SWAC_IDX_TAD_MAN = 8'h33;
   // Field positions
   localparam int SWAC_CTRL_PICK_LSB = 0;
   localparam int SWAC_CTRL_STEP_BIT = 4;
   localparam int SWAC_DELAY_FINE_STEPS_LSB = 0;
   localparam int SWAC_DELAY_COARSE_STEPS_LSB = 8;
   localparam int SWAC_CLOCK_INVERT_DELAY_BIT = 16;
   localparam int SWAC_STAT_DONE_BIT = 24;
   localparam int SWAC_STAT_BUSY_BIT = 25;
   localparam int SWAC_STAT_FOUND_BIT = 26;
   // Values after reset and counts
   localparam logic [3:0] SWAC_PICK_RST = 4'h0;
   localparam logic [7:0] SWAC_SETUP_RST = 8'h10;
   localparam logic [7:0] SWAC_TAD_RST = 8'h00;
   localparam logic [23:0] SWAC_MAP_RST = 24'h800001;
   localparam logic [1:0] SWAC_VALID_EDGES = 2'h3;
   localparam logic [7:0] SWAC_COARSE_LAST = 8'hff;
   typedef enum logic [2:0] {
      SWAC_S_IDLE = 3'b000,
      SWAC_S_SETTLE = 3'b001,
      SWAC_S_SAMPLE = 3'b010,
      SWAC_S_DONE = 3'b011
   } swac_srch_state_type;
endpackage

// ==== rtl/swac_window_map.sv ====
`timescale 1ns/100ps
module swac_window_map import swac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [SWAC_MAP_W-1:0] taps,
   input wire logic fine_step,
   output logic [SWAC_MAP_W-1:0] window_map,
   output logic map_valid,
   output logic [1:0] edge_count
);
   logic ref_prev_q;
   logic step_prev_q;
   logic [1:0] edge_q;
   logic [SWAC_MAP_W-1:0] acc_q;
   logic [SWAC_MAP_W-1:0] risk;

   // Earliest position marks the reference edge
   wire ref_rise = taps[0] & ~ref_prev_q;
   // New step size invalidates everything seen so far
   wire restart = fine_step != step_prev_q;
   wire more_edges = ref_rise && (edge_q != SWAC_VALID_EDGES);

   genvar i;
   generate
      for (i = 0; i < SWAC_MAP_W; i++) begin : g_risk
         if (i == 0 || i == SWAC_MAP_W - 1) begin : g_end
            assign risk[i] = 1'b1;
         end else begin : g_mid
            // Edge between neighbours means setup or hold risk
            assign risk[i] = (taps[i] ^ taps[i-1]) | (taps[i] ^ taps[i+1]);
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_q <= 1'b0;
         step_prev_q <= 1'b0;
         edge_q <= 2'h0;
         acc_q <= SWAC_MAP_RST;
      end else begin
         ref_prev_q <= taps[0];
         step_prev_q <= fine_step;
         if (restart) begin
            edge_q <= 2'h0;
            acc_q <= SWAC_MAP_RST;
         end else if (ref_rise) begin
            acc_q <= acc_q | risk;
            if (more_edges) begin
               edge_q <= edge_q + 2'h1;
            end
         end
      end
   end

   assign window_map = acc_q;
   assign map_valid = edge_q == SWAC_VALID_EDGES;
   assign edge_count = edge_q;
endmodule // swac_window_map

// ==== rtl/swac_cal_search.sv ====
`timescale 1ns/100ps
module swac_cal_search import swac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [7:0] settle_len,
   input wire logic align_late,
   output logic probe_inv,
   output logic [SWAC_TAD_W-1:0] probe_coarse,
   output logic busy,
   output logic finished,
   output logic found,
   output logic res_inv,
   output logic [SWAC_TAD_W-1:0] res_coarse
);
   swac_srch_state_type state_q, state_d;
   logic inv_q;
   logic have_prev_q;
   logic prev_q;
   logic best_ok_q;
   logic best_inv_q;
   logic finished_q;
   logic [7:0] coarse_q;
   logic [7:0] wait_q;
   logic [7:0] best_coarse_q;

   // Falling edge has just moved past the reference edge
   wire hit = have_prev_q & ~prev_q & align_late;
   wire better = hit & (~best_ok_q | (coarse_q < best_coarse_q));
   wire pass_end = hit | (coarse_q == SWAC_COARSE_LAST);
   wire [7:0] settle_load = (settle_len == 8'h00) ? 8'h01 : settle_len;
   wire start = (state_q == SWAC_S_IDLE) && (state_d == SWAC_S_SETTLE);

   always_comb begin
      case (state_q)
         SWAC_S_IDLE: state_d = (go && !finished_q) ? SWAC_S_SETTLE : SWAC_S_IDLE;
         SWAC_S_SETTLE: begin
            if (!go) state_d = SWAC_S_IDLE;
            else state_d = (wait_q == 8'h01) ? SWAC_S_SAMPLE : SWAC_S_SETTLE;
         end
         SWAC_S_SAMPLE: begin
            if (!go) state_d = SWAC_S_IDLE;
            else state_d = (pass_end && inv_q) ? SWAC_S_DONE : SWAC_S_SETTLE;
         end
         SWAC_S_DONE: state_d = SWAC_S_IDLE;
         default: state_d = SWAC_S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SWAC_S_IDLE;
         inv_q <= 1'b0;
         coarse_q <= 8'h00;
         wait_q <= 8'h00;
         have_prev_q <= 1'b0;
         prev_q <= 1'b0;
         best_ok_q <= 1'b0;
         best_inv_q <= 1'b0;
         best_coarse_q <= 8'h00;
         finished_q <= 1'b0;
      end else begin
         state_q <= state_d;
         // Completion wins over a clear in the same cycle
         finished_q <= (state_q == SWAC_S_DONE) | (finished_q & go);
         if (start) begin
            inv_q <= 1'b0;
            coarse_q <= 8'h00;
            wait_q <= settle_load;
            have_prev_q <= 1'b0;
            best_ok_q <= 1'b0;
            // No stale result from an earlier run
            best_inv_q <= 1'b0;
            best_coarse_q <= 8'h00;
         end else if (state_q == SWAC_S_SETTLE) begin
            wait_q <= wait_q - 8'h01;
         end else if (state_q == SWAC_S_SAMPLE) begin
            prev_q <= align_late;
            have_prev_q <= ~pass_end;
            wait_q <= settle_load;
            if (better) begin
               best_ok_q <= 1'b1;
               best_inv_q <= inv_q;
               best_coarse_q <= coarse_q;
            end
            // Second pass with inverted clock, restarting from zero
            if (pass_end) begin
               inv_q <= 1'b1;
               coarse_q <= 8'h00;
            end else begin
               coarse_q <= coarse_q + 8'h01;
            end
         end
      end
   end

   assign probe_inv = inv_q;
   assign probe_coarse = coarse_q;
   assign busy = (state_q == SWAC_S_SETTLE) || (state_q == SWAC_S_SAMPLE);
   assign finished = finished_q;
   assign found = best_ok_q;
   assign res_inv = best_inv_q;
   assign res_coarse = best_coarse_q;
endmodule // swac_cal_search

// ==== rtl/swac_top.sv ====
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// - Fine-step bit chooses coarse (0) or fine (1) spacing between positions.
// - Window map bits 0 and 23 always read one.
// - Pick value is the map bit index used to sample the reference.
// - Map has 24 flags; pick reaches only positions 0 to 15.
// - Go starts a delay search until falling edge meets reference edge.
// - Search sweeps coarse delay for both clock polarities, keeping the smallest.
// - Found delay is readable in the calibration status register.
// - Calibrated delay stays applied; after go clears, manual fields apply.
// - Finished flag rises at completion; software waits for it.
// - Map is valid only after three reference rising edges.
// - A one in the map flags a risky position, zero a usable one.
module swac_top import swac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [SWAC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [SWAC_MAP_W-1:0] sysref_taps,
   input wire logic align_late,
   output logic sysref_sampled,
   output logic delay_step_fine,
   output logic clock_invert_delay,
   output logic [SWAC_TAD_W-1:0] delay_coarse_steps,
   output logic [SWAC_TAD_W-1:0] delay_fine_steps
);
   logic [SWAC_PICK_W-1:0] pick_q;
   logic fine_q;
   logic go_q;
   logic [7:0] setup_q;
   logic man_inv_q;
   logic [SWAC_TAD_W-1:0] man_coarse_q;
   logic [SWAC_TAD_W-1:0] man_fine_q;
   logic [31:0] prdata_q;
   logic sampled_q;
   logic inv_out_q;
   logic [SWAC_TAD_W-1:0] coarse_out_q;
   logic [SWAC_TAD_W-1:0] fine_out_q;
   logic [31:0] rd_mux;

   logic [SWAC_MAP_W-1:0] window_map;
   logic map_valid;
   logic [1:0] edge_count;
   logic probe_inv;
   logic [SWAC_TAD_W-1:0] probe_coarse;
   logic busy;
   logic finished;
   logic found;
   logic res_inv;
   logic [SWAC_TAD_W-1:0] res_coarse;

   // Address decode: whole words only, upper bits must be clear
   wire word_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
   wire [7:0] idx = paddr[9:2];
   wire hit_ctrl = word_ok && (idx == SWAC_IDX_CLK_CTRL);
   wire hit_map_lo = word_ok && (idx == SWAC_IDX_MAP_LOW);
   wire hit_map_mid = word_ok && (idx == SWAC_IDX_MAP_MID);
   wire hit_map_hi = word_ok && (idx == SWAC_IDX_MAP_HIGH);
   wire hit_map_st = word_ok && (idx == SWAC_IDX_MAP_STAT);
   wire hit_go = word_ok && (idx == SWAC_IDX_CAL_GO);
   wire hit_setup = word_ok && (idx == SWAC_IDX_CAL_SETUP);
   wire hit_stat = word_ok && (idx == SWAC_IDX_CAL_STAT);
   wire hit_tad = word_ok && (idx == SWAC_IDX_TAD_MAN);
   wire mapped = hit_ctrl | hit_map_lo | hit_map_mid | hit_map_hi | hit_map_st |
                 hit_go | hit_setup | hit_stat | hit_tad;
   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire wr_en = access_ph & pwrite & mapped;
   wire wr_ctrl = wr_en & hit_ctrl & pstrb[0];
   wire wr_go = wr_en & hit_go & pstrb[0];
   wire wr_setup = wr_en & hit_setup & pstrb[0];
   wire wr_tad_f = wr_en & hit_tad & pstrb[0];
   wire wr_tad_c = wr_en & hit_tad & pstrb[1];
   wire wr_tad_i = wr_en & hit_tad & pstrb[2];

   // Read-back words
   wire [31:0] ctrl_word = {27'h0, fine_q, pick_q};
   wire [31:0] tad_word = {15'h0, man_inv_q, man_coarse_q, man_fine_q};
   wire [31:0] stat_word = {5'h0, found, busy, finished, 7'h0, res_inv, res_coarse, 8'h00};

   always_comb begin
      rd_mux = 32'h0;
      case (1'b1)
         hit_ctrl: rd_mux = ctrl_word;
         hit_map_lo: rd_mux = {24'h0, window_map[7:0]};
         hit_map_mid: rd_mux = {24'h0, window_map[15:8]};
         hit_map_hi: rd_mux = {24'h0, window_map[23:16]};
         hit_map_st: rd_mux = {31'h0, map_valid};
         hit_go: rd_mux = {31'h0, go_q};
         hit_setup: rd_mux = {24'h0, setup_q};
         hit_stat: rd_mux = stat_word;
         hit_tad: rd_mux = tad_word;
         default: rd_mux = 32'h0;
      endcase
   end

   // Zero wait states; read data settles during the setup cycle
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (setup_ph) begin
         prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pick_q <= SWAC_PICK_RST;
         fine_q <= 1'b0;
         go_q <= 1'b0;
         setup_q <= SWAC_SETUP_RST;
      end else begin
         if (wr_ctrl) begin
            // Field is four bits wide, so only positions 0 to 15 exist
            pick_q <= pwdata[SWAC_CTRL_PICK_LSB +: SWAC_PICK_W];
            fine_q <= pwdata[SWAC_CTRL_STEP_BIT];
         end
         if (wr_go) go_q <= pwdata[0];
         if (wr_setup) setup_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         man_inv_q <= 1'b0;
         man_coarse_q <= SWAC_TAD_RST;
         man_fine_q <= SWAC_TAD_RST;
      end else begin
         if (wr_tad_f) man_fine_q <= pwdata[SWAC_DELAY_FINE_STEPS_LSB +: SWAC_TAD_W];
         if (wr_tad_c) man_coarse_q <= pwdata[SWAC_DELAY_COARSE_STEPS_LSB +: SWAC_TAD_W];
         if (wr_tad_i) man_inv_q <= pwdata[SWAC_CLOCK_INVERT_DELAY_BIT];
      end
   end

   swac_window_map swac_window_map_inst (
      .pclk(pclk),
      .presetn(presetn),
      .taps(sysref_taps),
      .fine_step(fine_q),
      .window_map(window_map),
      .map_valid(map_valid),
      .edge_count(edge_count)
   );

   swac_cal_search swac_cal_search_inst (
      .pclk(pclk),
      .presetn(presetn),
      .go(go_q),
      .settle_len(setup_q),
      .align_late(align_late),
      .probe_inv(probe_inv),
      .probe_coarse(probe_coarse),
      .busy(busy),
      .finished(finished),
      .found(found),
      .res_inv(res_inv),
      .res_coarse(res_coarse)
   );

   // Delay source: search probe, calibrated result, or manual fields
   wire use_cal = go_q & finished;
   wire nxt_inv = busy ? probe_inv : (use_cal ? res_inv : man_inv_q);
   wire [SWAC_TAD_W-1:0] nxt_coarse = busy ? probe_coarse :
                                     (use_cal ? res_coarse : man_coarse_q);
   // Fine delay is left at zero by the search, so steps stay coarse-only
   wire [SWAC_TAD_W-1:0] nxt_fine = (busy | use_cal) ? SWAC_TAD_RST : man_fine_q;
   wire picked_tap = sysref_taps[pick_q];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inv_out_q <= 1'b0;
         coarse_out_q <= SWAC_TAD_RST;
         fine_out_q <= SWAC_TAD_RST;
         sampled_q <= 1'b0;
      end else begin
         inv_out_q <= nxt_inv;
         coarse_out_q <= nxt_coarse;
         fine_out_q <= nxt_fine;
         sampled_q <= picked_tap;
      end
   end

   assign clock_invert_delay = inv_out_q;
   assign delay_coarse_steps = coarse_out_q;
   assign delay_fine_steps = fine_out_q;
   assign sysref_sampled = sampled_q;
   assign delay_step_fine = fine_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ctrl_write;
      psel && penable && pwrite && hit_ctrl && pstrb[0];
   endsequence

   sequence s_go_rise;
      !go_q ##1 go_q && !finished;
   endsequence

   sequence s_search_ends;
      busy ##1 !busy && go_q;
   endsequence

   AST_MAP_ENDS_SET: assert property (window_map[0] && window_map[23])
      else $error("window map end bits not set");

   AST_PICK_SAMPLES_TAP: assert property ($stable(pick_q) |=>
      sampled_q == $past(sysref_taps[pick_q]))
      else $error("sampled reference not from picked position");

   AST_PICK_WRITE: assert property (s_ctrl_write |=>
      pick_q == $past(pwdata[3:0]))
      else $error("pick field did not take written value");

   AST_STEP_RESTARTS_MAP: assert property (s_ctrl_write ##1 $changed(fine_q) |=>
      !map_valid && edge_count == 2'h0 && delay_step_fine == $past(fine_q))
      else $error("step change did not restart the window map");

   AST_VALID_AFTER_THREE: assert property ($rose(map_valid) |->
      $past(edge_count) == 2'h2 && $past(sysref_taps[0]) && !$past(sysref_taps[0], 2))
      else $error("map valid without third reference edge");

   AST_MAP_RISK_STICKY: assert property (map_valid && $stable(fine_q) |=>
      (window_map & $past(window_map)) == $past(window_map))
      else $error("risk flag dropped while map valid");

   // Delay outputs lag the probe by one register stage
   AST_GO_STARTS_SEARCH: assert property (s_go_rise |=> busy ##1
      inv_out_q == 1'b0 && coarse_out_q == 8'h00)
      else $error("search did not start from zero delay");

   AST_SECOND_PASS: assert property (busy && $rose(probe_inv) |-> probe_coarse == 8'h00)
      else $error("inverted pass did not restart at zero");

   AST_BUSY_NOT_DONE: assert property (busy |-> !finished)
      else $error("finished high during search");

   // Set wins when go clears in the completion cycle
   AST_DONE_CLEARS: assert property (!go_q && !busy && !$past(busy) |=> !finished)
      else $error("finished stayed high after go cleared");

   AST_DONE_AFTER_SEARCH: assert property (s_search_ends |-> ##[0:1] finished)
      else $error("finished did not rise after search");

   AST_RESULT_APPLIED: assert property (go_q && finished && $stable(finished) |=>
      coarse_out_q == $past(res_coarse) && inv_out_q == $past(res_inv) && fine_out_q == 8'h00)
      else $error("calibrated delay not applied");

   AST_MANUAL_APPLIED: assert property (!go_q && !busy |=>
      coarse_out_q == $past(man_coarse_q) && fine_out_q == $past(man_fine_q))
      else $error("manual delay not applied");

   AST_UNMAPPED_ERR: assert property (psel && penable |-> pslverr == !mapped)
      else $error("error answer wrong for address");
endmodule // swac_top

// ==== tb/swac_ref_gen.sv ====
`timescale 1ns/100ps
module swac_ref_gen import swac_pkg::*; (
   input wire logic pclk,
   input wire logic run,
   input wire logic [4:0] edge_pos,
   input wire logic [SWAC_MAP_W-1:0] hold_pat,
   input wire logic [7:0] tgt0,
   input wire logic [7:0] tgt1,
   input wire logic clock_invert_delay,
   input wire logic [SWAC_TAD_W-1:0] delay_coarse_steps,
   output logic [SWAC_MAP_W-1:0] taps,
   output logic align_late
);
   logic [3:0] ph_q;
   initial begin
      ph_q = 4'h0;
      taps = '0;
   end
   // Continuous periodic reference while running, static level otherwise
   always @(posedge pclk) begin
      ph_q <= run ? ph_q + 4'h1 : 4'h0;
      if (!run)
         taps <= hold_pat;
      else if (ph_q == 4'h0)
         taps <= (24'h000002 << edge_pos) - 24'h000001;
      else
         taps <= {SWAC_MAP_W{ph_q < 4'h8}};
   end
   // Target zero never shows a low-to-high step, so that polarity finds nothing
   assign align_late = clock_invert_delay ? (delay_coarse_steps >= tgt1) :
                       (delay_coarse_steps >= tgt0);
endmodule // swac_ref_gen

// ==== tb/sysref_window_autocal_tb_top.sv ====
`timescale 1ns/100ps
module sysref_window_autocal_tb_top import swac_pkg::*; ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [SWAC_ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready, pslverr, sysref_sampled, delay_step_fine, clock_invert_delay, align_late, er;
   logic [SWAC_TAD_W-1:0] delay_coarse_steps, delay_fine_steps;
   wire [31:0] applied_delay = {15'h0, clock_invert_delay, delay_coarse_steps, delay_fine_steps};
   logic [SWAC_MAP_W-1:0] taps, em;
   logic [SWAC_MAP_W-1:0] hold_pat = '0;
   logic run = 1'b0;
   logic [4:0] edge_pos = '0;
   logic [4:0] k;
   logic [7:0] tgt0 = '0;
   logic [7:0] tgt1 = '0;
   logic [7:0] a, b, s;
   logic [31:0] seed = 32'h73face79;
   logic [31:0] rd, e;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   logic [7:0] ridx [9] = '{SWAC_IDX_CLK_CTRL, SWAC_IDX_MAP_LOW, SWAC_IDX_MAP_MID,
      SWAC_IDX_MAP_HIGH, SWAC_IDX_MAP_STAT, SWAC_IDX_CAL_GO, SWAC_IDX_CAL_SETUP,
      SWAC_IDX_CAL_STAT, SWAC_IDX_TAD_MAN};
   logic [31:0] rrst [9] = '{32'h0, 32'h01, 32'h0, 32'h80, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0};

   always #2.5 pclk = ~pclk;

   swac_top swac_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sysref_taps(taps), .align_late(align_late),
      .sysref_sampled(sysref_sampled), .delay_step_fine(delay_step_fine),
      .clock_invert_delay(clock_invert_delay), .delay_coarse_steps(delay_coarse_steps),
      .delay_fine_steps(delay_fine_steps));
   swac_ref_gen swac_ref_gen_inst (.pclk(pclk), .run(run), .edge_pos(edge_pos),
      .hold_pat(hold_pat), .tgt0(tgt0), .tgt1(tgt1), .clock_invert_delay(clock_invert_delay),
      .delay_coarse_steps(delay_coarse_steps), .taps(taps), .align_late(align_late));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
   endfunction
   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   function automatic logic [23:0] exp_map(input logic [4:0] kk);
      return SWAC_MAP_RST | ((24'h000003 << kk) & 24'h7ffffe);
   endfunction
   // Smallest coarse hit wins, non-inverted on a tie
   function automatic logic [31:0] exp_cal(input logic [7:0] t0, input logic [7:0] t1);
      logic [31:0] r;
      r = 32'h01000000;
      if (t0 != 8'h0 && (t1 == 8'h0 || t0 <= t1))
         r = r | 32'h04000000 | ({24'h0, t0} << 8);
      else if (t1 != 8'h0)
         r = r | 32'h04010000 | ({24'h0, t1} << 8);
      return r;
   endfunction

   task automatic conclude();
      $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   // Request held from setup until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, ba(idx), d);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, ba(idx), 32'h0);
      chk_val(rd & m, x, "register");
      chk_bit(er, 1'b0, "slave error");
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         rdchk(ridx[i], 32'hffffffff, rrst[i]);
      apb(1'b0, 12'h000, 32'h0);
      chk_bit(er, 1'b1, "unmapped error");
      chk_val(rd, 32'h0, "unmapped data");
      apb(1'b1, ba(SWAC_IDX_CLK_CTRL) | 12'h400, 32'h1f);
      chk_bit(er, 1'b1, "high address error");
      wr(SWAC_IDX_MAP_LOW, 32'hfe);
      rdchk(SWAC_IDX_MAP_LOW, 32'hffffffff, 32'h01);
      for (int p = 0; p < 16; p++) begin
         seed = lfsr(seed);
         hold_pat <= seed[23:0];
         wr(SWAC_IDX_CLK_CTRL, p);
         repeat (2) @(posedge pclk);
         chk_bit(sysref_sampled, seed[p], "sampled level");
      end
      wr(SWAC_IDX_CLK_CTRL, 32'hff);
      rdchk(SWAC_IDX_CLK_CTRL, 32'hffffffff, 32'h1f);
      // Each step toggle must wipe the flags left by the previous reference run
      for (int t = 0; t < 5; t++) begin
         seed = lfsr(seed);
         k = (t == 0) ? 5'd0 : (t == 1) ? 5'd22 : 5'(seed % 23);
         run <= 1'b0;
         hold_pat <= '0;
         wr(SWAC_IDX_CLK_CTRL, {27'h0, t[0], 4'h0});
         rdchk(SWAC_IDX_MAP_LOW, 32'hffffffff, 32'h01);
         // Step bit updates at the write edge, so look once it has settled
         chk_bit(delay_step_fine, t[0], "step select");
         edge_pos <= k;
         run <= 1'b1;
         repeat (2) @(posedge taps[0]);
         rdchk(SWAC_IDX_MAP_STAT, 32'hffffffff, 32'h0);
         @(posedge taps[0]);
         repeat (3) @(posedge pclk);
         rdchk(SWAC_IDX_MAP_STAT, 32'hffffffff, 32'h1);
         em = exp_map(k);
         rdchk(SWAC_IDX_MAP_LOW, 32'hffffffff, {24'h0, em[7:0]});
         rdchk(SWAC_IDX_MAP_MID, 32'hffffffff, {24'h0, em[15:8]});
         rdchk(SWAC_IDX_MAP_HIGH, 32'hffffffff, {24'h0, em[23:16]});
      end
      for (int t = 0; t < 5; t++) begin
         seed = lfsr(seed);
         // No-hit run follows a hit, so a stale result would show
         a = (t == 2) ? 8'h0 : (t == 1) ? 8'h05 : 8'(seed[7:0] % 40 + 1);
         b = (t == 2) ? 8'h0 : (t == 1) ? 8'h05 : 8'(seed[15:8] % 40 + 1);
         s = (t == 1) ? 8'h0 : 8'(seed[18:16] % 4 + 2);
         tgt0 <= a;
         tgt1 <= b;
         wr(SWAC_IDX_CLK_CTRL, 32'h0);
         wr(SWAC_IDX_CAL_SETUP, {24'h0, s});
         wr(SWAC_IDX_CAL_GO, 32'h1);
         rdchk(SWAC_IDX_CAL_STAT, 32'h03000000, 32'h02000000);
         n = 0;
         do begin
            apb(1'b0, ba(SWAC_IDX_CAL_STAT), 32'h0);
            n++;
         end while (rd[24] !== 1'b1 && n < 2000);
         e = exp_cal(a, b);
         rdchk(SWAC_IDX_CAL_STAT, 32'hffffffff, e);
         repeat (2) @(posedge pclk);
         chk_val(applied_delay, {15'h0, e[16:8], 8'h0}, "tad");
         wr(SWAC_IDX_CAL_GO, 32'h0);
         rdchk(SWAC_IDX_CAL_STAT, 32'h01000000, 32'h0);
         seed = lfsr(seed);
         wr(SWAC_IDX_TAD_MAN, {15'h0, seed[16:0]});
         repeat (2) @(posedge pclk);
         chk_val(applied_delay, {15'h0, seed[16:0]}, "manual");
      end
      conclude();
   end
endmodule // sysref_window_autocal_tb_top
